// ===== hdl/run_ref_pkg.sv
package run_ref_pkg;

  // Sizes of the terminal bank and of the reference words.
  localparam int N_TERM     = 9;
  localparam int FN_W       = 7;
  localparam int REF_W      = 16;
  localparam int STEP_CNT_W = 18;

  // Command source selection.
  localparam logic [1:0] SRC_KEYPAD   = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] SRC_FIELDBUS = 2'h2;

  // Terminal wiring modes.
  localparam logic [1:0] WM_TWO_WIRE_1   = 2'h0;
  localparam logic [1:0] WM_TWO_WIRE_2   = 2'h1;
  localparam logic [1:0] WM_THREE_WIRE_1 = 2'h2;
  localparam logic [1:0] WM_THREE_WIRE_2 = 2'h3;

  // Reference combination modes.
  localparam logic [2:0] CM_A   = 3'h0;
  localparam logic [2:0] CM_B   = 3'h1;
  localparam logic [2:0] CM_SUM = 3'h2;
  localparam logic [2:0] CM_DIF = 3'h3;
  localparam logic [2:0] CM_MAX = 3'h4;
  localparam logic [2:0] CM_MIN = 3'h5;

  // Terminal function codes; codes above FN_LAST never match anything.
  localparam logic [FN_W-1:0] FN_FWD         = 7'h01;
  localparam logic [FN_W-1:0] FN_REV         = 7'h02;
  localparam logic [FN_W-1:0] FN_THREE_WIRE  = 7'h03;
  localparam logic [FN_W-1:0] FN_JOG_FWD     = 7'h04;
  localparam logic [FN_W-1:0] FN_JOG_REV     = 7'h05;
  localparam logic [FN_W-1:0] FN_COAST       = 7'h06;
  localparam logic [FN_W-1:0] FN_FAULT_RESET = 7'h07;
  localparam logic [FN_W-1:0] FN_UP          = 7'h0a;
  localparam logic [FN_W-1:0] FN_DOWN        = 7'h0b;
  localparam logic [FN_W-1:0] FN_SWAP_AB     = 7'h0d;
  localparam logic [FN_W-1:0] FN_COMB_TO_A   = 7'h0e;
  localparam logic [FN_W-1:0] FN_COMB_TO_B   = 7'h0f;
  localparam logic [FN_W-1:0] FN_LAST        = 7'h5f;

  // Bit positions in the up/down channel configuration.
  localparam int UD_DISABLE_BIT = 0;
  localparam int UD_CLEAR_BIT   = 1;

  // Up/down step period and its cycle count at 5 ns per clock.
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int UPDOWN_STEP_US     = 1000;
  localparam int UPDOWN_STEP_CYCLES =
    (UPDOWN_STEP_US * 1000 * 1000) / CLK_PERIOD_PS;

  // Reference limits and reset value.
  localparam logic signed [REF_W-1:0] REF_MAX   = 16'sh7fff;
  localparam logic signed [REF_W-1:0] REF_MIN   = 16'sh8000;
  localparam logic signed [REF_W-1:0] REF_RESET = 16'sh0000;

  typedef enum logic [2:0] {
    RUN_STOP = 3'b001,
    RUN_FWD  = 3'b010,
    RUN_REV  = 3'b100
  } run_state_t;

  typedef struct packed {
    run_state_t              run;
    logic                    run_on;
    logic                    dir_rev;
    logic                    led;
    logic                    relatch;
    logic                    jog_fwd;
    logic                    jog_rev;
    logic                    coast;
    logic                    fault_reset;
    logic [STEP_CNT_W-1:0]   step_cnt;
    logic signed [REF_W-1:0] updown_acc;
    logic signed [REF_W-1:0] freq_ref;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{run: RUN_STOP, default: '0};

  // Saturates a widened sum back into the reference range.
  function automatic logic signed [REF_W-1:0] clip_ref(
    input logic signed [REF_W+1:0] v
  );
    logic signed [REF_W+1:0] hi;
    logic signed [REF_W+1:0] lo;
    hi = {{2{REF_MAX[REF_W-1]}}, REF_MAX};
    lo = {{2{REF_MIN[REF_W-1]}}, REF_MIN};
    if (v > hi) begin
      clip_ref = REF_MAX;
    end else if (v < lo) begin
      clip_ref = REF_MIN;
    end else begin
      clip_ref = v[REF_W-1:0];
    end
  endfunction

endpackage

// ===== hdl/term_sync_if.sv
`timescale 1ns/1ps
interface term_sync_if
  import run_ref_pkg::*;
();
  logic [N_TERM-1:0] level;
  logic [N_TERM-1:0] rise;
  logic [N_TERM-1:0] fall;

  modport producer (output level, output rise, output fall);
  modport consumer (input level, input rise, input fall);
endinterface

// ===== hdl/terminal_sync.sv
`timescale 1ns/1ps
module terminal_sync
  import run_ref_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [N_TERM-1:0] pin_in,
  term_sync_if.producer          tsync
);

  typedef struct packed {
    logic [N_TERM-1:0] meta;
    logic [N_TERM-1:0] stable;
    logic [N_TERM-1:0] prev;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // Two stages settle the contacts; the third keeps the last settled level.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = pin_in;
    s_nxt.stable = s_r.meta;
    s_nxt.prev   = s_r.stable;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Edges come only from settled stages, so each lasts exactly one cycle.
  for (genvar i = 0; i < N_TERM; i++) begin : g_edge
    assign tsync.level[i] = s_r.stable[i];
    assign tsync.rise[i]  = s_r.stable[i] & ~s_r.prev[i];
    assign tsync.fall[i]  = ~s_r.stable[i] & s_r.prev[i];
  end

  a_rise_single: assert property (
    @(posedge clk) disable iff (srst)
    |tsync.rise |=> ((tsync.rise & $past(tsync.rise)) == '0)
  ) else $error("terminal rising edge lasted more than one cycle");

endmodule

// ===== hdl/ref_combine.sv
`timescale 1ns/1ps
module ref_combine
  import run_ref_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic [2:0]              combine_mode,
  input  wire logic                    swap_ab,
  input  wire logic                    comb_to_a,
  input  wire logic                    comb_to_b,
  input  wire logic signed [REF_W-1:0] ref_a,
  input  wire logic signed [REF_W-1:0] ref_b,
  output logic signed [REF_W-1:0]      combined
);

  typedef struct packed {
    logic signed [REF_W-1:0] combined;
  } comb_state_t;

  comb_state_t             s_r;
  comb_state_t             s_nxt;
  logic signed [REF_W+1:0] a_x;
  logic signed [REF_W+1:0] b_x;
  logic [2:0]              eff_mode;

  // Terminal overrides pick the effective mode before the arithmetic.
  always_comb begin
    s_nxt    = s_r;
    a_x      = {{2{ref_a[REF_W-1]}}, ref_a};
    b_x      = {{2{ref_b[REF_W-1]}}, ref_b};
    eff_mode = combine_mode;
    if (combine_mode == CM_A && swap_ab) begin
      eff_mode = CM_B;
    end else if (combine_mode == CM_B && swap_ab) begin
      eff_mode = CM_A;
    end else if (combine_mode >= CM_SUM && combine_mode <= CM_MIN) begin
      if (comb_to_a) begin
        eff_mode = CM_A;
      end else if (comb_to_b) begin
        eff_mode = CM_B;
      end
    end
    // Unused mode codes fall back to channel A rather than to zero.
    case (eff_mode)
      CM_B:    s_nxt.combined = ref_b;
      CM_SUM:  s_nxt.combined = clip_ref(a_x + b_x);
      CM_DIF:  s_nxt.combined = clip_ref(a_x - b_x);
      CM_MAX:  s_nxt.combined = (ref_a > ref_b) ? ref_a : ref_b;
      CM_MIN:  s_nxt.combined = (ref_a < ref_b) ? ref_a : ref_b;
      default: s_nxt.combined = ref_a;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign combined = s_r.combined;

  a_sum_mode: assert property (
    @(posedge clk) disable iff (srst)
    (combine_mode == CM_SUM && !comb_to_a && !comb_to_b)
      |=> (combined == clip_ref($past(a_x) + $past(b_x)))
  ) else $error("sum mode did not give A plus B");

endmodule

// ===== hdl/run_command_and_reference_select.sv
`timescale 1ns/1ps
module run_command_and_reference_select
  import run_ref_pkg::*;
#(
  parameter int STEP_CYCLES = UPDOWN_STEP_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic [1:0]                command_source_select,
  input  wire logic [1:0]                terminal_wiring_mode,
  input  wire logic [2:0]                reference_combine_mode,
  input  wire logic [N_TERM-1:0][FN_W-1:0] input_terminal_function,
  input  wire logic [7:0]                digital_input_terminals,
  input  wire logic                      pulse_input_terminal,
  input  wire logic                      key_run,
  input  wire logic                      key_stop,
  input  wire logic                      stop_key_scope_setting,
  input  wire logic                      external_stop,
  input  wire logic                      bus_start,
  input  wire logic                      bus_stop,
  input  wire logic                      bus_reverse,
  input  wire logic                      bus_jog,
  input  wire logic signed [REF_W-1:0]   ref_a,
  input  wire logic signed [REF_W-1:0]   ref_b,
  input  wire logic [1:0]                updown_channel_config,
  input  wire logic [REF_W-1:0]          up_rate_setting,
  input  wire logic [REF_W-1:0]          down_rate_setting,
  output logic                           run_cmd,
  output logic                           dir_rev,
  output logic                           jog_fwd,
  output logic                           jog_rev,
  output logic                           run_led,
  output logic                           coast_stop,
  output logic                           fault_reset,
  output logic signed [REF_W-1:0]        freq_ref
);

  ctrl_state_t             s_r;
  ctrl_state_t             s_nxt;
  run_state_t              want;
  logic                    other_stop;
  logic                    two_wire;
  logic                    step;
  logic signed [REF_W-1:0] combined;
  logic [N_TERM-1:0]       fwd_lv;
  logic [N_TERM-1:0]       fwd_up;
  logic [N_TERM-1:0]       rev_lv;
  logic [N_TERM-1:0]       rev_up;
  logic [N_TERM-1:0]       rev_dn;
  logic [N_TERM-1:0]       en_lv;
  logic [N_TERM-1:0]       jf_lv;
  logic [N_TERM-1:0]       jr_lv;
  logic [N_TERM-1:0]       coast_lv;
  logic [N_TERM-1:0]       frst_up;
  logic [N_TERM-1:0]       up_lv;
  logic [N_TERM-1:0]       dn_lv;
  logic [N_TERM-1:0]       swap_lv;
  logic [N_TERM-1:0]       to_a_lv;
  logic [N_TERM-1:0]       to_b_lv;
  logic                    fwd_any;
  logic                    fwd_rise;
  logic                    rev_any;
  logic                    rev_rise;
  logic                    rev_chg;
  logic                    en_any;
  logic                    coast_any;

  term_sync_if tsync ();

  // Every contact, including the pulse terminal, passes the synchroniser.
  terminal_sync u_sync (
    .clk    (clk),
    .srst   (srst),
    .pin_in ({pulse_input_terminal, digital_input_terminals}),
    .tsync  (tsync)
  );

  // Per-terminal function match; unlisted codes simply match nothing.
  for (genvar i = 0; i < N_TERM; i++) begin : g_decode
    logic [FN_W-1:0] fn;
    logic            lv;
    assign fn          = input_terminal_function[i];
    assign lv          = tsync.level[i];
    assign fwd_lv[i]   = lv & (fn == FN_FWD);
    assign fwd_up[i]   = tsync.rise[i] & (fn == FN_FWD);
    assign rev_lv[i]   = lv & (fn == FN_REV);
    assign rev_up[i]   = tsync.rise[i] & (fn == FN_REV);
    assign rev_dn[i]   = tsync.fall[i] & (fn == FN_REV);
    assign en_lv[i]    = lv & (fn == FN_THREE_WIRE);
    assign jf_lv[i]    = lv & (fn == FN_JOG_FWD);
    assign jr_lv[i]    = lv & (fn == FN_JOG_REV);
    assign coast_lv[i] = lv & (fn == FN_COAST);
    assign frst_up[i]  = tsync.rise[i] & (fn == FN_FAULT_RESET);
    assign up_lv[i]    = lv & (fn == FN_UP);
    assign dn_lv[i]    = lv & (fn == FN_DOWN);
    assign swap_lv[i]  = lv & (fn == FN_SWAP_AB);
    assign to_a_lv[i]  = lv & (fn == FN_COMB_TO_A);
    assign to_b_lv[i]  = lv & (fn == FN_COMB_TO_B);
  end

  // Any terminal with the function counts, as contacts are wired in parallel.
  assign fwd_any   = |fwd_lv;
  assign fwd_rise  = |fwd_up;
  assign rev_any   = |rev_lv;
  assign rev_rise  = |rev_up;
  assign rev_chg   = |(rev_up | rev_dn);
  assign en_any    = |en_lv;
  assign coast_any = |coast_lv;

  // Main channel combiner, registered once before the final sum.
  ref_combine u_comb (
    .clk          (clk),
    .srst         (srst),
    .combine_mode (reference_combine_mode),
    .swap_ab      (|swap_lv),
    .comb_to_a    (|to_a_lv),
    .comb_to_b    (|to_b_lv),
    .ref_a        (ref_a),
    .ref_b        (ref_b),
    .combined     (combined)
  );

  // Stop sources outside the selected channel; the stop key only counts
  // here when its scope covers the other channels.
  assign other_stop = external_stop
    | (stop_key_scope_setting & key_stop
       & (command_source_select != SRC_KEYPAD));
  assign two_wire = (command_source_select == SRC_TERMINAL)
    & (terminal_wiring_mode[1] == 1'b0);
  assign step = (s_r.step_cnt == STEP_CNT_W'(STEP_CYCLES - 1));

  // Command arbitration, run state and up/down channel in one pass.
  always_comb begin
    s_nxt             = s_r;
    want              = s_r.run;
    s_nxt.fault_reset = 1'b0;
    s_nxt.jog_fwd     = 1'b0;
    s_nxt.jog_rev     = 1'b0;
    case (command_source_select)
      SRC_KEYPAD: begin
        if (key_stop) begin
          want = RUN_STOP;
        end else if (key_run) begin
          want = RUN_FWD;
        end
      end
      SRC_TERMINAL: begin
        s_nxt.fault_reset = |frst_up;
        s_nxt.jog_fwd     = (|jf_lv) & ~(|jr_lv);
        s_nxt.jog_rev     = (|jr_lv) & ~(|jf_lv);
        case (terminal_wiring_mode)
          WM_TWO_WIRE_1: begin
            if (fwd_any && !rev_any) begin
              want = RUN_FWD;
            end else if (!fwd_any && rev_any) begin
              want = RUN_REV;
            end else if (!fwd_any && !rev_any) begin
              want = RUN_STOP;
            end
          end
          WM_TWO_WIRE_2: begin
            if (!fwd_any) begin
              want = RUN_STOP;
            end else if (rev_any) begin
              want = RUN_REV;
            end else begin
              want = RUN_FWD;
            end
          end
          WM_THREE_WIRE_1: begin
            if (!en_any) begin
              want = RUN_STOP;
            end else if (s_r.run == RUN_STOP) begin
              if (fwd_rise) begin
                want = rev_any ? RUN_REV : RUN_FWD;
              end
            end else if (rev_chg) begin
              want = (s_r.run == RUN_FWD) ? RUN_REV : RUN_FWD;
            end
          end
          WM_THREE_WIRE_2: begin
            if (!en_any) begin
              want = RUN_STOP;
            end else if (fwd_rise) begin
              want = RUN_FWD;
            end else if (rev_rise) begin
              want = RUN_REV;
            end
          end
          default: want = RUN_STOP;
        endcase
      end
      SRC_FIELDBUS: begin
        s_nxt.jog_fwd = bus_jog & ~bus_reverse;
        s_nxt.jog_rev = bus_jog & bus_reverse;
        if (bus_stop) begin
          want = RUN_STOP;
        end else if (bus_start) begin
          want = bus_reverse ? RUN_REV : RUN_FWD;
        end
      end
      default: want = RUN_STOP;
    endcase

    // A foreign stop or a coast arms the latch; only a fresh edge, a release or leaving two-wire control disarms.
    if (!two_wire) begin
      s_nxt.relatch = 1'b0;
    end else if (other_stop || coast_any) begin
      s_nxt.relatch = 1'b1;
    end else if (fwd_rise || rev_rise || (!fwd_any && !rev_any)) begin
      s_nxt.relatch = 1'b0;
    end
    if (two_wire && s_nxt.relatch) begin
      want = RUN_STOP;
    end
    if (other_stop || coast_any) begin
      want = RUN_STOP;
    end

    // Jog is only honoured from standstill and never against a foreign stop or a coast.
    if (want != RUN_STOP || other_stop || coast_any) begin
      s_nxt.jog_fwd = 1'b0;
      s_nxt.jog_rev = 1'b0;
    end

    s_nxt.run     = want;
    s_nxt.run_on  = (want != RUN_STOP);
    s_nxt.dir_rev = (want == RUN_REV);
    s_nxt.led     = (want != RUN_STOP);
    s_nxt.coast   = coast_any;

    // The step counter free-runs so the ramp rate does not depend on
    // when a contact closes; the cost is up to one step of latency.
    s_nxt.step_cnt = step ? '0 : s_r.step_cnt + 1'b1;
    if (updown_channel_config[UD_CLEAR_BIT] && want == RUN_STOP) begin
      s_nxt.updown_acc = REF_RESET;
    end else if (step && !updown_channel_config[UD_DISABLE_BIT]) begin
      if ((|up_lv) && !(|dn_lv)) begin
        s_nxt.updown_acc = clip_ref({{2{s_r.updown_acc[REF_W-1]}},
          s_r.updown_acc} + {2'h0, up_rate_setting});
      end else if ((|dn_lv) && !(|up_lv)) begin
        s_nxt.updown_acc = clip_ref({{2{s_r.updown_acc[REF_W-1]}},
          s_r.updown_acc} - {2'h0, down_rate_setting});
      end
    end
    s_nxt.freq_ref = clip_ref({{2{combined[REF_W-1]}}, combined}
      + {{2{s_r.updown_acc[REF_W-1]}}, s_r.updown_acc});
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign run_cmd     = s_r.run_on;
  assign dir_rev     = s_r.dir_rev;
  assign jog_fwd     = s_r.jog_fwd;
  assign jog_rev     = s_r.jog_rev;
  assign run_led     = s_r.led;
  assign coast_stop  = s_r.coast;
  assign fault_reset = s_r.fault_reset;
  assign freq_ref    = s_r.freq_ref;

  a_keypad_run: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_KEYPAD && key_run && !key_stop
      && !external_stop && !coast_any) |=> (run_cmd && !dir_rev)
  ) else $error("keypad run key did not start forward");

  a_keypad_stop: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_KEYPAD && key_stop && run_cmd)
      |=> (!run_cmd && !run_led)
  ) else $error("keypad stop key did not stop the drive");

  a_led_follow: assert property (
    @(posedge clk) disable iff (srst)
    run_led == run_cmd
  ) else $error("running indicator disagrees with run state");

  a_two_wire_idle: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_TERMINAL
      && terminal_wiring_mode == WM_TWO_WIRE_1 && !fwd_any && !rev_any)
      |=> !run_cmd
  ) else $error("two-wire mode 1 ran with both inputs open");

  a_two_wire_rev: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_TERMINAL
      && terminal_wiring_mode == WM_TWO_WIRE_2 && fwd_any && rev_any
      && !other_stop && !coast_any
      && (!s_r.relatch || fwd_rise || rev_rise))
      |=> (run_cmd && dir_rev)
  ) else $error("two-wire mode 2 did not run reverse");

  a_relatch_block: assert property (
    @(posedge clk) disable iff (srst)
    (two_wire && s_r.relatch && !fwd_rise && !rev_rise) |=> !run_cmd
  ) else $error("drive restarted without a fresh activation");

  a_three_wire_off: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_TERMINAL && terminal_wiring_mode[1]
      && !en_any) |=> !run_cmd
  ) else $error("three-wire mode ran with enable open");

  a_dir_flip: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_TERMINAL
      && terminal_wiring_mode == WM_THREE_WIRE_1 && en_any && run_cmd
      && rev_chg && !other_stop && !coast_any)
      |=> (run_cmd && (dir_rev != $past(dir_rev)))
  ) else $error("reverse level change did not flip direction");

  a_three_wire2_rev: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_TERMINAL
      && terminal_wiring_mode == WM_THREE_WIRE_2 && en_any && !fwd_rise
      && rev_rise && !other_stop && !coast_any) |=> (run_cmd && dir_rev)
  ) else $error("reverse edge did not run reverse");

  a_coast_stop: assert property (
    @(posedge clk) disable iff (srst)
    coast_any |=> (!run_cmd && coast_stop)
  ) else $error("coast stop terminal did not stop the drive");

  a_bus_start: assert property (
    @(posedge clk) disable iff (srst)
    (command_source_select == SRC_FIELDBUS && bus_start && !bus_stop
      && !other_stop && !coast_any)
      |=> (run_cmd && dir_rev == $past(bus_reverse))
  ) else $error("fieldbus start was not taken");

endmodule

// ===== sim/field_side.sv
`timescale 1ns/1ps
module field_side (
  input  wire logic       clk,
  input  wire logic [7:0] want_pins,
  input  wire logic [2:0] want_bus,
  output logic [7:0]      pins = 8'h00,
  output logic [2:0]      bus = 3'h0
);
  // Contacts and the master's start, stop and direction levels move one
  // edge after the bench asks, as a real far side never answers at once.
  always @(posedge clk) begin
    pins <= want_pins;
    bus <= want_bus;
  end
endmodule

// ===== sim/run_command_and_reference_select_tb.sv
`timescale 1ns/1ps
module run_command_and_reference_select_tb import run_ref_pkg::*; ;
  logic        clk = 1'b0, srst = 1'b1, ext_stop = 1'b0;
  logic        key_run = 1'b0, key_stop = 1'b0, run_cmd, dir_rev, run_led;
  logic        coast;
  logic [1:0]  src = 2'h0, wmode = 2'h0;
  logic [2:0]  cmode = 3'h0, want_bus = 3'h0, bus;
  logic [7:0]  want_pins = 8'h00, pins;
  logic [15:0] rate = 16'h0001;
  logic signed [REF_W-1:0] ref_a = 16'sh0064, ref_b = 16'shffec, freq_ref;
  int          mismatches = 0, n_compared = 0, cycles = 0;
  wire [N_TERM-1:0][FN_W-1:0] fn =
    {7'h00, FN_COMB_TO_B, FN_SWAP_AB, FN_COAST, FN_DOWN, FN_UP,
     FN_THREE_WIRE, FN_REV, FN_FWD}; // Terminals 8 down to 0.
  field_side field_side_i (.clk(clk), .want_pins(want_pins),
    .want_bus(want_bus), .pins(pins), .bus(bus));
  run_command_and_reference_select #(.STEP_CYCLES(8))
      run_command_and_reference_select_i (.clk(clk), .srst(srst),
    .command_source_select(src), .terminal_wiring_mode(wmode),
    .reference_combine_mode(cmode), .input_terminal_function(fn),
    .digital_input_terminals(pins), .pulse_input_terminal(1'b0),
    .key_run(key_run), .key_stop(key_stop), .stop_key_scope_setting(1'b0),
    .external_stop(ext_stop), .bus_start(bus[0]), .bus_stop(bus[1]),
    .bus_reverse(bus[2]), .bus_jog(1'b0), .ref_a(ref_a), .ref_b(ref_b),
    .updown_channel_config(2'h0), .up_rate_setting(rate),
    .down_rate_setting(rate), .run_cmd(run_cmd), .dir_rev(dir_rev),
    .jog_fwd(), .jog_rev(), .run_led(run_led), .coast_stop(coast),
    .fault_reset(), .freq_ref(freq_ref));
  initial forever #2.5 clk = ~clk;
  // The tests need about 250 cycles, so a hang is cut off at 1000, four times that.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Word digits: source, wiring mode, contacts, commands, expected state.
  // Keys last one cycle, since a held key acts again on every edge; the
  // contacts stay as set. Five edges cover the far side plus the 3 stages.
  task automatic act(input logic [27:0] w);
    @(posedge clk);
    src <= w[25:24];
    wmode <= w[21:20];
    want_pins <= w[19:12];
    {ext_stop, key_run, key_stop, want_bus} <= w[9:4];
    @(posedge clk);
    {ext_stop, key_run, key_stop, want_bus} <= 6'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({run_cmd, run_led, dir_rev & run_cmd}, w[2:0]);
  endtask
  task automatic t_sources();
    logic [27:0] tab [6] = '{28'h0_0_00_10_6, 28'h0_0_00_08_0,
      28'h2_0_00_05_7, 28'h2_0_00_08_7, 28'h2_0_00_02_0, 28'h1_0_00_10_0};
    foreach (tab[i]) act(tab[i]);
    $display("source test done");
  endtask
  // Each wiring mode is walked through starts, direction changes and stops.
  task automatic t_terminals();
    logic [27:0] tab [20] = '{28'h1_0_01_00_6, 28'h1_0_03_00_6,
      28'h1_0_02_00_7, 28'h1_0_02_20_0, 28'h1_0_02_00_0, 28'h1_0_00_00_0,
      28'h1_0_02_00_7, 28'h1_1_02_00_0, 28'h1_1_03_00_7, 28'h1_1_01_00_6,
      28'h1_1_00_00_0, 28'h1_2_04_00_0, 28'h1_2_05_00_6, 28'h1_2_06_00_7,
      28'h1_2_04_00_6, 28'h1_2_00_00_0, 28'h1_3_04_00_0, 28'h1_3_06_00_7,
      28'h1_3_05_00_6, 28'h1_3_01_00_0};
    foreach (tab[i]) act(tab[i]);
    $display("terminal test done");
  endtask
  // Channel B is negative, so sum, difference and minimum all differ.
  task automatic t_combine();
    logic [15:0] exp [6] = '{16'h0064, 16'hffec, 16'h0050, 16'h0078,
      16'h0064, 16'hffec};
    for (int m = 0; m < 6; m++) begin
      @(posedge clk);
      cmode <= 3'(m);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(freq_ref, exp[m]);
    end
    $display("combine test done");
  endtask
  // Windows of whole step periods give an exact step count whatever the
  // phase of the free-running counter: 4 up, 2 down at rate 1.
  task automatic t_updown();
    @(posedge clk);
    cmode <= 3'h0;
    want_pins <= 8'h08;
    repeat (32) @(posedge clk);
    want_pins <= 8'h10;
    repeat (16) @(posedge clk);
    want_pins <= 8'h60;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(freq_ref, 16'hffee);
    chk({15'h0000, coast}, 16'h0001);
    @(posedge clk);
    want_pins <= 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(freq_ref, 16'h0066);
    chk({15'h0000, coast}, 16'h0000);
    $display("up/down test done");
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Reset is held for 16 edges, which also flushes the synchronisers.
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_sources();
    t_terminals();
    t_combine();
    t_updown();
    complete_run();
  end
endmodule
